/* rtl/avo_regs.sv */
/*
  Volume and output configuration register bank reached over the two-wire
  control port, with fault latching and decoded settings for the datapath.
  Assumes the host clocks the port far slower than mclk (several mclk per
  phase) and that rate_speed_select comes from logic clocked by mclk.
*/
`timescale 1ns/1ps
module avo_regs #(
  parameter logic [6:0] DEV_ADDR = avo_pkg::DEV_ADDR_DFLT
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Two-wire control port pins
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Fault sense and shutdown pins
  input wire logic speaker_shutdown_ctrl_n,
  input wire logic clock_fault_in,
  input wire logic overcurrent_in,
  input wire logic dc_offset_in,
  input wire logic overtemp_in,
  // Sample-rate mode from the serial audio control
  input wire logic rate_speed_select,
  // Channel gain to the datapath
  output logic signed [8:0] left_gain_halfdb,
  output logic signed [8:0] right_gain_halfdb,
  output logic left_mute,
  output logic right_mute,
  // Output stage settings
  output logic parallel_bridged_mono,
  output logic mono_source_left,
  output logic [4:0] switch_rate_multiple,
  output logic [1:0] analog_gain_code,
  output logic [6:0] overcurrent_trip_pct,
  // Fault status
  output logic clock_fault_flag,
  output logic overcurrent_fault_flag,
  output logic dc_offset_fault_flag,
  output logic overtemp_fault_flag,
  output logic amp_halt
);

  // ---------------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------------
  logic [6:0] pins_s;
  logic scl_s, sda_s, sd_n_s, clkf_s, oc_s, dc_s, ot_s;
  logic scl_d_reg, sda_d_reg;

  avo_sync #(.WIDTH(7), .RST_VAL(avo_pkg::PIN_IDLE)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in({scl_pin, sda_in, speaker_shutdown_ctrl_n, clock_fault_in,
               overcurrent_in, dc_offset_in, overtemp_in}),
    .sync_out(pins_s)
  );
  assign {scl_s, sda_s, sd_n_s, clkf_s, oc_s, dc_s, ot_s} = pins_s;

  // Delayed copies for edge finding; idle bus is high
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  logic scl_rise, scl_fall, start_seen, stop_seen;
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_seen = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_seen = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ---------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------
  logic [7:0] left_reg, left_next, right_reg, right_next, cfg_reg, cfg_next;
  logic [1:0] trip_reg, trip_next;
  logic oc_reg, oc_next, dc_reg, dc_next, ot_reg, ot_next, clkf_reg, clkf_next;

  // Read mux shared by both points that load a read byte
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    case (a)
      avo_pkg::REG_LEFT_GAIN: rd_byte = left_reg;
      avo_pkg::REG_RIGHT_GAIN: rd_byte = right_reg;
      avo_pkg::REG_OUT_CFG: rd_byte = cfg_reg;
      avo_pkg::REG_FAULT: rd_byte = {2'h0, trip_reg, clkf_reg, oc_reg, dc_reg, ot_reg}; // R14
      default: rd_byte = 8'h00;
    endcase
  endfunction

  // Volume code to signed half-dB steps around unity
  function automatic logic signed [8:0] to_halfdb(input logic [7:0] c);
    to_halfdb = $signed({1'b0, c}) - $signed({1'b0, avo_pkg::VOL_UNITY_CODE}); // R15
  endfunction

  // ---------------------------------------------------------------------
  // Control port state machine
  // ---------------------------------------------------------------------
  avo_pkg::avo_state_t state_reg, state_next;
  logic [7:0] shift_reg, shift_next, ptr_reg, ptr_next;
  logic [3:0] cnt_reg, cnt_next;
  logic rw_reg, rw_next, nack_reg, nack_next, oe_reg, oe_next;
  logic wr_en;
  logic [7:0] wr_addr, wr_data, rd_now;
  logic byte_done;

  assign byte_done = scl_fall && (cnt_reg == avo_pkg::BYTE_BITS);

  // Next state of the port; stop and start win over any bit in flight
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    cnt_next = cnt_reg;
    rw_next = rw_reg;
    nack_next = nack_reg;
    oe_next = oe_reg;
    wr_en = 1'b0;
    wr_addr = ptr_reg;
    wr_data = shift_reg;
    rd_now = rd_byte(ptr_reg);
    if (stop_seen) begin
      state_next = avo_pkg::ST_IDLE;
      oe_next = 1'b0;
    end else if (start_seen) begin
      state_next = avo_pkg::ST_ADDR;
      cnt_next = 4'h0;
      oe_next = 1'b0;
    end else begin
      case (state_reg)
        avo_pkg::ST_ADDR, avo_pkg::ST_PTR, avo_pkg::ST_WDATA: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s};
            cnt_next = cnt_reg + 4'h1;
          end else if (byte_done) begin
            cnt_next = 4'h0;
            oe_next = 1'b1;
            if (state_reg == avo_pkg::ST_ADDR) begin
              rw_next = shift_reg[0];
              state_next = avo_pkg::ST_AACK;
              // Another address: stay off the bus
              if (shift_reg[7:1] != DEV_ADDR) begin
                oe_next = 1'b0;
                state_next = avo_pkg::ST_IDLE;
              end
            end else if (state_reg == avo_pkg::ST_PTR) begin
              ptr_next = shift_reg;
              state_next = avo_pkg::ST_PACK;
            end else begin
              wr_en = 1'b1;
              ptr_next = ptr_reg + 8'h01;
              state_next = avo_pkg::ST_WACK;
            end
          end
        end
        avo_pkg::ST_AACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              shift_next = rd_now;
              oe_next = ~rd_now[7];
              cnt_next = 4'h1;
              state_next = avo_pkg::ST_RDATA;
            end else begin
              oe_next = 1'b0;
              state_next = avo_pkg::ST_PTR;
            end
          end
        end
        avo_pkg::ST_PACK, avo_pkg::ST_WACK: begin
          if (scl_fall) begin
            oe_next = 1'b0;
            state_next = avo_pkg::ST_WDATA;
          end
        end
        avo_pkg::ST_RDATA: begin
          if (byte_done) begin
            oe_next = 1'b0;
            ptr_next = ptr_reg + 8'h01;
            state_next = avo_pkg::ST_MACK;
          end else if (scl_fall) begin
            // Open drain: a one is sent by releasing the line
            oe_next = ~shift_reg[6];
            shift_next = {shift_reg[6:0], 1'b0};
            cnt_next = cnt_reg + 4'h1;
          end
        end
        avo_pkg::ST_MACK: begin
          if (scl_rise) begin
            nack_next = sda_s;
          end else if (scl_fall) begin
            if (nack_reg) begin
              state_next = avo_pkg::ST_IDLE;
            end else begin
              shift_next = rd_now;
              oe_next = ~rd_now[7];
              cnt_next = 4'h1;
              state_next = avo_pkg::ST_RDATA;
            end
          end
        end
        avo_pkg::ST_IDLE: begin
          oe_next = 1'b0;
        end
        default: begin
          state_next = avo_pkg::ST_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  // Port registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= avo_pkg::ST_IDLE;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      cnt_reg <= 4'h0;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      cnt_reg <= cnt_next;
      rw_reg <= rw_next;
      nack_reg <= nack_next;
      oe_reg <= oe_next;
    end
  end
  assign sda_oe = oe_reg;
  assign sda_out = 1'b0; // Line is only ever pulled low

  // ---------------------------------------------------------------------
  // Register writes and fault latching
  // ---------------------------------------------------------------------
  // Writes to the reserved slot and unmapped offsets are dropped
  always_comb begin
    left_next = left_reg;
    right_next = right_reg;
    cfg_next = cfg_reg;
    trip_next = trip_reg;
    if (wr_en) begin
      case (wr_addr)
        avo_pkg::REG_LEFT_GAIN: left_next = wr_data; // R5
        avo_pkg::REG_RIGHT_GAIN: right_next = wr_data; // R5
        avo_pkg::REG_OUT_CFG: cfg_next = wr_data; // R12
        avo_pkg::REG_FAULT: trip_next = wr_data[avo_pkg::TRIP_MSB:avo_pkg::TRIP_LSB]; // R14
        default: left_next = left_reg; // R13
      endcase
    end
    // Shutdown held low clears; a fault present at the same time wins
    oc_next = (oc_reg & sd_n_s) | oc_s; // R18
    dc_next = (dc_reg & sd_n_s) | dc_s; // R18
    ot_next = (ot_reg & sd_n_s) | ot_s; // R18
    clkf_next = clkf_s; // R17
  end

  // Bank registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      left_reg <= avo_pkg::GAIN_RST; // R2
      right_reg <= avo_pkg::GAIN_RST; // R2
      cfg_reg <= avo_pkg::OUT_CFG_RST; // R6 R9 R11 R12
      trip_reg <= avo_pkg::TRIP_RST;
      oc_reg <= 1'b0;
      dc_reg <= 1'b0;
      ot_reg <= 1'b0;
      clkf_reg <= 1'b0;
    end else begin
      left_reg <= left_next;
      right_reg <= right_next;
      cfg_reg <= cfg_next;
      trip_reg <= trip_next;
      oc_reg <= oc_next;
      dc_reg <= dc_next;
      ot_reg <= ot_next;
      clkf_reg <= clkf_next;
    end
  end
  assign clock_fault_flag = clkf_reg;
  assign overcurrent_fault_flag = oc_reg;
  assign dc_offset_fault_flag = dc_reg;
  assign overtemp_fault_flag = ot_reg;

  // ---------------------------------------------------------------------
  // Decoded settings for the datapath
  // ---------------------------------------------------------------------
  logic signed [8:0] lg_next, rg_next;
  logic lm_next, rm_next, mono_next, src_next, halt_next;
  logic [4:0] base_rate, mult_next;
  logic [6:0] pct_next;

  // Registered decode costs one cycle of lag but keeps outputs glitch free
  always_comb begin
    lg_next = to_halfdb(left_reg); // R1 R3
    rg_next = to_halfdb(right_reg); // R1 R3
    lm_next = left_reg < avo_pkg::VOL_MUTE_BELOW; // R4
    rm_next = right_reg < avo_pkg::VOL_MUTE_BELOW; // R4
    mono_next = cfg_reg[avo_pkg::MONO_BIT]; // R6
    src_next = cfg_reg[avo_pkg::SRC_BIT]; // R7
    case (cfg_reg[avo_pkg::RATE_MSB:avo_pkg::RATE_LSB]) // R8
      3'h0: base_rate = avo_pkg::RATE_X0;
      3'h1: base_rate = avo_pkg::RATE_X1;
      3'h2: base_rate = avo_pkg::RATE_X2;
      3'h3: base_rate = avo_pkg::RATE_X3;
      3'h4: base_rate = avo_pkg::RATE_X4;
      3'h5: base_rate = avo_pkg::RATE_X5;
      3'h6: base_rate = avo_pkg::RATE_X6;
      default: base_rate = avo_pkg::RATE_X7;
    endcase
    mult_next = rate_speed_select ? {1'b0, base_rate[4:1]} : base_rate; // R10
    case (trip_reg) // R16
      2'h0: pct_next = avo_pkg::TRIP_PCT_0;
      2'h1: pct_next = avo_pkg::TRIP_PCT_1;
      2'h2: pct_next = avo_pkg::TRIP_PCT_2;
      default: pct_next = avo_pkg::TRIP_PCT_3;
    endcase
    halt_next = oc_reg | dc_reg | ot_reg | clkf_reg | ~sd_n_s; // R17 R18
  end

  // Output registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      left_gain_halfdb <= 9'h000;
      right_gain_halfdb <= 9'h000;
      left_mute <= 1'b0;
      right_mute <= 1'b0;
      parallel_bridged_mono <= 1'b0;
      mono_source_left <= 1'b0;
      switch_rate_multiple <= avo_pkg::RATE_X5;
      analog_gain_code <= 2'h0;
      overcurrent_trip_pct <= avo_pkg::TRIP_PCT_0;
      amp_halt <= 1'b1;
    end else begin
      left_gain_halfdb <= lg_next;
      right_gain_halfdb <= rg_next;
      left_mute <= lm_next;
      right_mute <= rm_next;
      parallel_bridged_mono <= mono_next;
      mono_source_left <= src_next;
      switch_rate_multiple <= mult_next;
      analog_gain_code <= cfg_reg[avo_pkg::AGAIN_MSB:avo_pkg::AGAIN_LSB]; // R11
      overcurrent_trip_pct <= pct_next;
      amp_halt <= halt_next;
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence seq_wr_left;
    wr_en && (wr_addr == avo_pkg::REG_LEFT_GAIN);
  endsequence
  sequence seq_mono_left;
    cfg_reg[avo_pkg::MONO_BIT] && cfg_reg[avo_pkg::SRC_BIT];
  endsequence

  AST_WR_LEFT: assert property (seq_wr_left |=> left_reg == $past(wr_data) && right_reg == $past(right_reg)) // R5
    else $error("left gain write not captured alone");
  AST_TOP_GAIN: assert property (right_reg == 8'hFF |=> right_gain_halfdb == 9'h030) // R1
    else $error("full-scale code not +24 dB");
  AST_UNITY: assert property (left_reg == 8'hCF |=> left_gain_halfdb == 9'h000 && !left_mute) // R2
    else $error("unity code not 0 dB");
  AST_FLOOR: assert property (left_reg == 8'h07 |=> left_gain_halfdb == 9'h138 && !left_mute) // R3
    else $error("floor code not -100 dB unmuted");
  AST_MUTE: assert property (right_reg < 8'h07 |=> right_mute) // R4
    else $error("low code did not mute");
  AST_MONO: assert property (seq_mono_left |=> parallel_bridged_mono && mono_source_left) // R7
    else $error("mono source not left");
  AST_RATE_SS: assert property (cfg_reg[6:4] == 3'h5 && !rate_speed_select |=> switch_rate_multiple == 5'h10) // R9
    else $error("rate code 5 not 16x");
  AST_RATE_DS: assert property (cfg_reg[6:4] == 3'h7 && rate_speed_select |=> switch_rate_multiple == 5'h0C) // R10
    else $error("double speed not halved");
  AST_TRIP: assert property (trip_reg == 2'h2 |=> overcurrent_trip_pct == 7'h32) // R16
    else $error("trip code 2 not 50 percent");
  AST_CLKF: assert property (!clkf_s |=> !clock_fault_flag) // R17
    else $error("clock fault latched");
  AST_LATCH: assert property (oc_reg && sd_n_s |=> oc_reg ##1 amp_halt) // R18
    else $error("overcurrent did not hold and halt");
endmodule // avo_regs

/* inc/avo_pkg.sv */
/*
  Constants, register map, field layout and state encoding of the amplifier
  volume and output configuration register bank.
  Assumes a single clock domain (mclk) for everything that uses it.
*/
// Functional notes
// (R1) Volume registers are eight bits; 0xFF is +24 dB, 0xFE is +23.5 dB.
// (R2) Code 0xCF is unity gain; both volume registers reset to it.
// (R3) Code 0x07 is the lowest unmuted gain, -100 dB.
// (R4) Any volume code below 0x07 mutes that channel.
// (R5) Left gain from offset 0x04, right from 0x05, set independently.
// (R6) Output config bit 7: clear bridged stereo, set parallel-bridged mono; resets 0.
// (R7) In mono mode bit 1 picks source: clear right, set left.
// (R8) Bits 6:4 pick switching rate 6,8,10,12,14,16,20,24 times frame rate.
// (R9) Switching-rate field resets to 101, sixteen times frame rate.
// (R10) Double-speed sample rates halve the switching rate.
// (R11) Analog gain bits 3:2 reset 00; 00,01,10 valid; host never writes 11.
// (R12) Output config bit 0 resets to 1; host writes it back unchanged.
// (R13) Host neither writes nor trusts offset 0x07.
// (R14) Offset 0x08: trip level bits 5:4 writable; fault status bits 3..0 read-only.
// (R15) Volume steps 0.5 dB per code between +24 dB and -100 dB.
// (R16) Trip code 00 nominal, 01 75%, 10 50%, 11 25%.
// (R17) Clock fault status does not latch; clears when clocks recover.
// (R18) Other faults latch and halt; toggling shutdown clears them.
package avo_pkg;

  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] REG_LEFT_GAIN = 8'h04;
  localparam logic [7:0] REG_RIGHT_GAIN = 8'h05;
  localparam logic [7:0] REG_OUT_CFG = 8'h06;
  localparam logic [7:0] REG_RESERVED = 8'h07;
  localparam logic [7:0] REG_FAULT = 8'h08;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] GAIN_RST = 8'hCF;
  localparam logic [7:0] OUT_CFG_RST = 8'h51;
  localparam logic [1:0] TRIP_RST = 2'h0;
  localparam logic [6:0] PIN_IDLE = 7'h70; // Port clock, data and shutdown_n high; faults low

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int MONO_BIT = 7;
  localparam int RATE_MSB = 6;
  localparam int RATE_LSB = 4;
  localparam int AGAIN_MSB = 3;
  localparam int AGAIN_LSB = 2;
  localparam int SRC_BIT = 1;
  localparam int TRIP_MSB = 5;
  localparam int TRIP_LSB = 4;

  // ---------------------------------------------------------------------
  // Volume coding
  // ---------------------------------------------------------------------
  localparam logic [7:0] VOL_UNITY_CODE = 8'hCF;
  localparam logic [7:0] VOL_MUTE_BELOW = 8'h07;

  // ---------------------------------------------------------------------
  // Switching-rate multiples of the frame rate, codes 0..7
  // ---------------------------------------------------------------------
  localparam logic [4:0] RATE_X0 = 5'h06;
  localparam logic [4:0] RATE_X1 = 5'h08;
  localparam logic [4:0] RATE_X2 = 5'h0A;
  localparam logic [4:0] RATE_X3 = 5'h0C;
  localparam logic [4:0] RATE_X4 = 5'h0E;
  localparam logic [4:0] RATE_X5 = 5'h10;
  localparam logic [4:0] RATE_X6 = 5'h14;
  localparam logic [4:0] RATE_X7 = 5'h18;

  // ---------------------------------------------------------------------
  // Overcurrent trip level in percent of nominal
  // ---------------------------------------------------------------------
  localparam logic [6:0] TRIP_PCT_0 = 7'h64;
  localparam logic [6:0] TRIP_PCT_1 = 7'h4B;
  localparam logic [6:0] TRIP_PCT_2 = 7'h32;
  localparam logic [6:0] TRIP_PCT_3 = 7'h19;

  // ---------------------------------------------------------------------
  // Control port
  // ---------------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h2A; // Arbitrary value

  // One-hot states of the two-wire port
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_AACK  = 9'h004,
    ST_PTR   = 9'h008,
    ST_PACK  = 9'h010,
    ST_WDATA = 9'h020,
    ST_WACK  = 9'h040,
    ST_RDATA = 9'h080,
    ST_MACK  = 9'h100
  } avo_state_t;

endpackage

/* rtl/avo_sync.sv */
/*
  Two-stage synchroniser for a bundle of independent level inputs.
  Assumes each bit is a level whose transitions may be arbitrary.
*/
`timescale 1ns/1ps
module avo_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Raw and synchronised levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // First stage is read only by the second; reset to idle levels so no false edge follows
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // avo_sync

/* tb/avo_host_model.sv */
/*
  Behavioural host on the two-wire control port: start, stop, byte
  transfers and register write/read sequences.
  Assumes mclk as the pacing clock and a pull-up on the data wire.
*/
`timescale 1ns/1ps
module avo_host_model (
  // Clock
  input wire logic mclk,
  // Port wires
  output logic scl_pin,
  output logic sda_in,
  input wire logic sda_oe
);
  // ---------------------------------------------------------------
  // Wire resolution
  // ---------------------------------------------------------------
  logic sda_low;
  // Open drain with pull-up: low if either party pulls
  assign sda_in = ~(sda_low | sda_oe);
  // Idle bus at time zero
  initial begin
    scl_pin = 1'b1;
    sda_low = 1'b0;
  end
  // ---------------------------------------------------------------
  // Bit level, phases of 6 and 7 cycles give a link period of 65 ns
  // ---------------------------------------------------------------
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic bit_out(input logic b);
    sda_low <= ~b;
    hold(3);
    scl_pin <= 1'b1;
    hold(7);
    scl_pin <= 1'b0;
    hold(3);
  endtask
  task automatic bit_in(output logic b);
    sda_low <= 1'b0;
    hold(3);
    scl_pin <= 1'b1;
    hold(4);
    b = sda_in;
    hold(3);
    scl_pin <= 1'b0;
    hold(3);
  endtask
  // Also serves as repeated start, data released while clock is low
  task automatic start();
    sda_low <= 1'b0;
    hold(3);
    scl_pin <= 1'b1;
    hold(4);
    sda_low <= 1'b1;
    hold(4);
    scl_pin <= 1'b0;
    hold(3);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    hold(3);
    scl_pin <= 1'b1;
    hold(4);
    sda_low <= 1'b0;
    hold(4);
  endtask
  // ---------------------------------------------------------------
  // Byte and register level
  // ---------------------------------------------------------------
  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
    ack = ~a;
  endtask
  task automatic wr_reg(input logic [6:0] dev, input logic [7:0] p, d, output logic ack);
    logic a0, a1, a2;
    start();
    byte_out({dev, 1'b0}, a0);
    byte_out(p, a1);
    byte_out(d, a2);
    stop();
    ack = a0 & a1 & a2;
  endtask
  // Single byte read, ended by a master NACK
  task automatic rd_reg(input logic [7:0] p, output logic [7:0] d);
    logic a;
    start();
    byte_out({avo_pkg::DEV_ADDR_DFLT, 1'b0}, a);
    byte_out(p, a);
    start();
    byte_out({avo_pkg::DEV_ADDR_DFLT, 1'b1}, a);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(1'b1);
    stop();
  endtask
endmodule // avo_host_model

/* tb/test_avo_regs.sv */
/*
  Self-checking bench of the register bank through the two-wire port.
  Assumes avo_pkg compiled first and the host model beside it.
*/
`timescale 1ns/1ps
module test_avo_regs;
  logic mclk, sys_rst, scl_pin, sda_in, sda_out, sda_oe, sd_n, dbl, lm, rm, mono, srcl, halt;
  logic [3:0] flt;
  wire [3:0] fl;
  logic signed [8:0] lg, rg;
  logic [4:0] rate;
  logic [1:0] ag;
  logic [6:0] pct;
  int error_cnt = 0;
  int n_checks = 0;
  // ---------------------------------------------------------------
  // Design and host
  // ---------------------------------------------------------------
  avo_regs uut (.mclk(mclk), .sys_rst(sys_rst), .scl_pin(scl_pin), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .speaker_shutdown_ctrl_n(sd_n), .clock_fault_in(flt[3]), .overcurrent_in(flt[2]),
    .dc_offset_in(flt[1]), .overtemp_in(flt[0]), .rate_speed_select(dbl), .left_gain_halfdb(lg),
    .right_gain_halfdb(rg), .left_mute(lm), .right_mute(rm), .parallel_bridged_mono(mono),
    .mono_source_left(srcl), .switch_rate_multiple(rate), .analog_gain_code(ag), .overcurrent_trip_pct(pct),
    .clock_fault_flag(fl[3]), .overcurrent_fault_flag(fl[2]), .dc_offset_fault_flag(fl[1]),
    .overtemp_fault_flag(fl[0]), .amp_halt(halt));
  avo_host_model host (.mclk(mclk), .scl_pin(scl_pin), .sda_in(sda_in), .sda_oe(sda_oe));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [8:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [7:0] p, d);
    logic a;
    host.wr_reg(avo_pkg::DEV_ADDR_DFLT, p, d, a);
    chk("ack", 9'h001, {8'h00, a});
  endtask
  task automatic rd(input logic [7:0] p, e);
    logic [7:0] d;
    host.rd_reg(p, d);
    chk("read", {1'b0, e}, {1'b0, d});
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(8'h04, 8'hCF);
    rd(8'h05, 8'hCF);
    rd(8'h06, 8'h51);
    rd(8'h08, 8'h00);
    chk("gain", 9'h000, lg);
    chk("rate", 9'h010, {4'h0, rate});
    chk("pct", 9'h064, {2'b00, pct});
    chk("mono", 9'h000, {8'h00, mono});
    chk("again", 9'h000, {7'h00, ag});
    chk("sda_out", 9'h000, {8'h00, sda_out});
  endtask
  // Edge codes of the volume scale, last one left in place
  task automatic t_volume();
    logic [7:0] c [0:4];
    c = '{8'hFF, 8'hFE, 8'hCF, 8'h07, 8'h06};
    for (int i = 0; i < 5; i++) begin
      wr(8'h04, c[i]);
      chk("left_gain", {1'b0, c[i]} - 9'd207, lg);
      chk("left_mute", {8'h00, c[i] < 8'h07}, {8'h00, lm});
      chk("right_gain", 9'h000, rg);
    end
    wr(8'h05, 8'hFF);
    chk("right_gain", 9'h030, rg);
    wr(8'h05, 8'h00);
    chk("right_mute", 9'h001, {8'h00, rm});
    rd(8'h05, 8'h00);
  endtask
  // Every rate and valid analog code, reserved bit written back as 1
  task automatic t_outcfg();
    int m [0:7];
    logic [7:0] v;
    logic [2:0] r3;
    logic [1:0] g;
    m = '{6, 8, 10, 12, 14, 16, 20, 24};
    for (int r = 0; r < 8; r++) begin
      r3 = r[2:0];
      g = 2'(r % 3);
      v = {1'b1, r3, g, r3[0], 1'b1};
      wr(8'h06, v);
      chk("rate", 9'(m[r]), {4'h0, rate});
      chk("mono", 9'h001, {8'h00, mono});
      chk("src", {8'h00, r3[0]}, {8'h00, srcl});
      chk("again", {7'h00, g}, {7'h00, ag});
      rd(8'h06, v);
    end
    dbl <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("rate_half", 9'h00C, {4'h0, rate});
    dbl <= 1'b0;
    wr(8'h06, 8'h51);
    chk("mono", 9'h000, {8'h00, mono});
  endtask
  task automatic t_fault();
    logic [6:0] p [0:3];
    p = '{7'h64, 7'h4B, 7'h32, 7'h19};
    for (int t = 0; t < 4; t++) begin
      wr(8'h08, {2'b11, 2'(t), 4'hF});
      chk("pct", {2'b00, p[t]}, {2'b00, pct});
      rd(8'h08, {2'b00, 2'(t), 4'h0});
    end
    flt <= 4'h8;
    repeat (8) @(posedge mclk);
    chk("flags", 9'h008, {5'h00, fl});
    flt <= 4'h0;
    repeat (8) @(posedge mclk);
    chk("flags", 9'h000, {5'h00, fl});
    flt <= 4'h7;
    repeat (8) @(posedge mclk);
    flt <= 4'h0;
    repeat (8) @(posedge mclk);
    chk("flags", 9'h007, {5'h00, fl});
    chk("halt", 9'h001, {8'h00, halt});
    rd(8'h08, 8'h37);
    sd_n <= 1'b0;
    repeat (8) @(posedge mclk);
    sd_n <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("flags", 9'h000, {5'h00, fl});
    chk("halt", 9'h000, {8'h00, halt});
  endtask
  // Foreign address is not answered and changes nothing
  // Slot 0x07 is never written by any scenario
  task automatic t_address();
    logic a;
    host.wr_reg(avo_pkg::DEV_ADDR_DFLT ^ 7'h01, 8'h04, 8'h55, a);
    chk("nack", 9'h000, {8'h00, a});
    rd(8'h04, 8'h06);
    rd(8'h09, 8'h00);
  endtask
  // Two data bytes in one transfer land at consecutive offsets
  task automatic t_burst();
    logic a0, a1, a2, a3;
    host.start();
    host.byte_out({avo_pkg::DEV_ADDR_DFLT, 1'b0}, a0);
    host.byte_out(8'h04, a1);
    host.byte_out(8'hD1, a2);
    host.byte_out(8'hCD, a3);
    host.stop();
    chk("burst_ack", 9'h001, {8'h00, a0 & a1 & a2 & a3});
    chk("left_gain", 9'h002, lg);
    chk("right_gain", 9'h1FE, rg);
  endtask
  // ---------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    sys_rst = 1'b1;
    flt = 4'h0;
    sd_n = 1'b1;
    dbl = 1'b0;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge mclk);
    t_reset();
    t_volume();
    t_outcfg();
    t_fault();
    t_address();
    t_burst();
    report_and_stop();
  end
  // Whole run needs about 18600 cycles
  initial begin
    repeat (90000) @(posedge mclk);
    error_cnt++;
    report_and_stop();
  end
endmodule // test_avo_regs
